// [pct_timer_regs.vh]
// Purpose: constants for the PWM and capture/compare timer
// Assumes: byte-wide register port, 20 MHz core clock
// Notes: offsets are byte addresses on the register port
// Function
// - Two period-select bits choose 16, 15, 14 or 13 bit PWM period.
// - Control bit 7 routes PWM to the pin, else pin is data output.
// - Duty bits above the selected resolution are ignored.
// - After a low-byte write, next counter wrap loads the duty buffer.
// - Low-byte write in the same cycle as a wrap does not transfer then.
// - Low-byte write alone arms transfer using the previous high byte.
// - PWM high time in cycles equals the buffered duty value.
// - Shared counter counts every cycle, resets to zero, reads harmless.
// - Counter high write is buffered; low write loads both bytes.
// - Counter low read latches high byte for a later high read.
// - Status register fully readable, low five bits writable only.
// - Overflow flag in bit 5 sets when the counter wraps.
// - Compare flag in bit 6 sets when counter equals compare register.
// - Selected capture edge copies counter and sets capture flag bit 7.
// - On match, output-level bit drives compare pin if misc bit 6 set.
// - Edge bit picks falling or rising; capture needs misc bit 7 set.
// - Control bit 2 enables interrupt request from overflow flag.
// - Control bit 3 enables interrupt request from compare flag.
// - Control bit 4 enables interrupt request from capture flag.
// - Overflow flag clears on status read then counter low read.
// - Compare flag clears on status read then compare low write.
// - Capture flag clears on status read then capture low read.
`ifndef PCT_TIMER_REGS_VH
`define PCT_TIMER_REGS_VH
`define PCT_ADDR_PWM_CTRL 8'h12
`define PCT_ADDR_DUTY_HI 8'h13
`define PCT_ADDR_DUTY_LO 8'h14
`define PCT_ADDR_TCS 8'h15
`define PCT_ADDR_FRC_HI 8'h16
`define PCT_ADDR_FRC_LO 8'h17
`define PCT_ADDR_OCR_HI 8'h18
`define PCT_ADDR_OCR_LO 8'h19
`define PCT_ADDR_ICR_HI 8'h1a
`define PCT_ADDR_ICR_LO 8'h1b
`define PCT_ADDR_MISC 8'h3b
`define PCT_ADDR_PORT_DATA 8'h3c
`define PCT_BIT_PWM_EN 7
`define PCT_BIT_OUTPUT_LEVEL_BIT 0
`define PCT_BIT_EDGE_SELECT_BIT 1
`define PCT_BIT_TOIE 2
`define PCT_BIT_OCIE 3
`define PCT_BIT_ICIE 4
`define PCT_BIT_TOF 5
`define PCT_BIT_OCF 6
`define PCT_BIT_ICF 7
`define PCT_BIT_MISC_TOUT 6
`define PCT_BIT_MISC_TIN 7
`define PCT_OCR_RESET 16'hffff
`define PCT_CNT_MAX 16'hffff
`endif

// [pct_timer.v]
// Purpose: shared 16-bit counter with PWM, output compare and input capture
// Assumes: one cycle of core_clk is one E cycle; capture pin is asynchronous
// Notes: unmapped reads return zero; write-only registers read as zero
`timescale 1ns/1ps
`include "pct_timer_regs.vh"
module pct_timer (
    core_clk,
    arst_n,
    regAddr,
    regWrData,
    regWrStb,
    regRdStb,
    regRdData,
    capturePin,
    pwmPin,
    compareOutPin,
    compareOutEn,
    timerIrq
);
input wire core_clk;
input wire arst_n;
input wire [7:0] regAddr;
input wire [7:0] regWrData;
input wire regWrStb;
input wire regRdStb;
output reg [7:0] regRdData;
input wire capturePin;
output reg pwmPin;
output reg compareOutPin;
output reg compareOutEn;
output reg timerIrq;

reg [15:0] counter_reg;
reg [7:0] wrBuf_reg;
reg [7:0] rdBuf_reg;
reg [7:0] icrBuf_reg;
reg [7:0] pwmCtrl_reg;
reg [7:0] dutyHi_reg;
reg [7:0] dutyLo_reg;
reg [15:0] dutyBuf_reg;
reg armed_reg;
reg [4:0] ctrl_reg;
reg tof_reg;
reg ocf_reg;
reg icf_reg;
reg tofSeen_reg;
reg ocfSeen_reg;
reg icfSeen_reg;
reg [15:0] ocr_reg;
reg [7:0] ocrHiBuf_reg;
reg [15:0] icr_reg;
reg [7:0] misc_reg;
reg portData_reg;
reg capSync1_reg;
reg capSync2_reg;
reg capPrev_reg;
reg compareLevel_reg;
reg [7:0] rdNext;

wire wrPwmCtrl = regWrStb && regAddr == `PCT_ADDR_PWM_CTRL;
wire wrDutyHi = regWrStb && regAddr == `PCT_ADDR_DUTY_HI;
wire wrDutyLo = regWrStb && regAddr == `PCT_ADDR_DUTY_LO;
wire wrTcs = regWrStb && regAddr == `PCT_ADDR_TCS;
wire wrFrcHi = regWrStb && regAddr == `PCT_ADDR_FRC_HI;
wire wrFrcLo = regWrStb && regAddr == `PCT_ADDR_FRC_LO;
wire wrOcrHi = regWrStb && regAddr == `PCT_ADDR_OCR_HI;
wire wrOcrLo = regWrStb && regAddr == `PCT_ADDR_OCR_LO;
wire wrMisc = regWrStb && regAddr == `PCT_ADDR_MISC;
wire wrPort = regWrStb && regAddr == `PCT_ADDR_PORT_DATA;
wire rdTcs = regRdStb && regAddr == `PCT_ADDR_TCS;
wire rdFrcLo = regRdStb && regAddr == `PCT_ADDR_FRC_LO;
wire rdIcrLo = regRdStb && regAddr == `PCT_ADDR_ICR_LO;

wire wrapEvt = counter_reg == `PCT_CNT_MAX && !wrFrcLo;
// Compare inhibited during a high-byte write of compare or counter
wire matchEvt = counter_reg == ocr_reg && !wrOcrHi && !wrFrcHi;
wire capEdge = misc_reg[`PCT_BIT_MISC_TIN] &&
    (ctrl_reg[`PCT_BIT_EDGE_SELECT_BIT] ? (capSync2_reg && !capPrev_reg) : (!capSync2_reg && capPrev_reg));

function [15:0] resMask;
    input [1:0] sel;
    begin
        case (sel)
            2'b00: resMask = 16'hffff;
            2'b01: resMask = 16'h7fff;
            2'b10: resMask = 16'h3fff;
            default: resMask = 16'h1fff;
        endcase
    end
endfunction

wire [15:0] pwmMask = resMask(pwmCtrl_reg[1:0]);
wire pwmHigh = (counter_reg & pwmMask) < (dutyBuf_reg & pwmMask);

// Read mux; registers that are write-only read back as zero
always @* begin
    if (regAddr == `PCT_ADDR_PWM_CTRL) begin
        rdNext = pwmCtrl_reg;
    end else if (regAddr == `PCT_ADDR_TCS) begin
        rdNext = {icf_reg, ocf_reg, tof_reg, ctrl_reg};
    end else if (regAddr == `PCT_ADDR_FRC_HI) begin
        rdNext = rdBuf_reg;
    end else if (regAddr == `PCT_ADDR_FRC_LO) begin
        rdNext = counter_reg[7:0];
    end else if (regAddr == `PCT_ADDR_OCR_HI) begin
        rdNext = ocr_reg[15:8];
    end else if (regAddr == `PCT_ADDR_OCR_LO) begin
        rdNext = ocr_reg[7:0];
    end else if (regAddr == `PCT_ADDR_ICR_HI) begin
        rdNext = icrBuf_reg;
    end else if (regAddr == `PCT_ADDR_ICR_LO) begin
        rdNext = icr_reg[7:0];
    end else if (regAddr == `PCT_ADDR_MISC) begin
        rdNext = misc_reg;
    end else if (regAddr == `PCT_ADDR_PORT_DATA) begin
        rdNext = {7'h00, portData_reg};
    end else begin
        rdNext = 8'h00;
    end
end

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        regRdData <= 8'h00;
        counter_reg <= 16'h0000;
        wrBuf_reg <= 8'h00;
        rdBuf_reg <= 8'h00;
        icrBuf_reg <= 8'h00;
        pwmCtrl_reg <= 8'h00;
        dutyHi_reg <= 8'h00;
        dutyLo_reg <= 8'h00;
        dutyBuf_reg <= 16'h0000;
        armed_reg <= 1'b0;
        ctrl_reg <= 5'h00;
        tof_reg <= 1'b0;
        ocf_reg <= 1'b0;
        icf_reg <= 1'b0;
        tofSeen_reg <= 1'b0;
        ocfSeen_reg <= 1'b0;
        icfSeen_reg <= 1'b0;
        ocr_reg <= `PCT_OCR_RESET;
        ocrHiBuf_reg <= 8'hff;
        icr_reg <= 16'h0000;
        misc_reg <= 8'h00;
        portData_reg <= 1'b0;
        capSync1_reg <= 1'b0;
        capSync2_reg <= 1'b0;
        capPrev_reg <= 1'b0;
        compareLevel_reg <= 1'b0;
        pwmPin <= 1'b0;
        compareOutPin <= 1'b0;
        compareOutEn <= 1'b0;
        timerIrq <= 1'b0;
    end else begin
        regRdData <= regRdStb ? rdNext : 8'h00;
        capSync1_reg <= capturePin;
        capSync2_reg <= capSync1_reg;
        capPrev_reg <= capSync2_reg;
        if (wrPwmCtrl) begin
            pwmCtrl_reg <= {regWrData[7], 5'h00, regWrData[1:0]};
        end
        if (wrMisc) begin
            misc_reg <= regWrData;
        end
        if (wrPort) begin
            portData_reg <= regWrData[0];
        end
        if (wrTcs) begin
            ctrl_reg <= regWrData[4:0];
        end
        if (wrFrcHi) begin
            wrBuf_reg <= regWrData;
        end
        if (wrFrcLo) begin
            counter_reg <= {wrBuf_reg, regWrData};
        end else begin
            counter_reg <= counter_reg + 16'h0001;
        end
        if (rdFrcLo) begin
            rdBuf_reg <= counter_reg[15:8];
        end
        if (rdIcrLo) begin
            icrBuf_reg <= icr_reg[15:8];
        end
        if (wrOcrHi) begin
            ocrHiBuf_reg <= regWrData;
        end
        if (wrOcrLo) begin
            ocr_reg <= {ocrHiBuf_reg, regWrData};
        end
        if (wrDutyHi) begin
            dutyHi_reg <= regWrData;
        end
        if (wrDutyLo) begin
            dutyLo_reg <= regWrData;
        end
        if (wrDutyLo) begin
            armed_reg <= 1'b1;
        end else if (wrapEvt && armed_reg) begin
            armed_reg <= 1'b0;
            dutyBuf_reg <= {dutyHi_reg, dutyLo_reg};
        end
        if (capEdge) begin
            icr_reg <= counter_reg;
        end
        // Arm clear after a status read that saw the flag; set beats clear
        if (rdTcs) begin
            tofSeen_reg <= tof_reg;
            ocfSeen_reg <= ocf_reg;
            icfSeen_reg <= icf_reg;
        end
        if (wrapEvt) begin
            tof_reg <= 1'b1;
        end else if (rdFrcLo && tofSeen_reg) begin
            tof_reg <= 1'b0;
            tofSeen_reg <= 1'b0;
        end
        if (matchEvt) begin
            ocf_reg <= 1'b1;
        end else if (wrOcrLo && ocfSeen_reg) begin
            ocf_reg <= 1'b0;
            ocfSeen_reg <= 1'b0;
        end
        if (capEdge) begin
            icf_reg <= 1'b1;
        end else if (rdIcrLo && icfSeen_reg) begin
            icf_reg <= 1'b0;
            icfSeen_reg <= 1'b0;
        end
        if (matchEvt) begin
            compareLevel_reg <= ctrl_reg[`PCT_BIT_OUTPUT_LEVEL_BIT];
        end
        compareOutPin <= matchEvt ? ctrl_reg[`PCT_BIT_OUTPUT_LEVEL_BIT] : compareLevel_reg;
        compareOutEn <= misc_reg[`PCT_BIT_MISC_TOUT];
        pwmPin <= pwmCtrl_reg[`PCT_BIT_PWM_EN] ? pwmHigh : portData_reg;
        timerIrq <= (tof_reg && ctrl_reg[`PCT_BIT_TOIE]) ||
            (ocf_reg && ctrl_reg[`PCT_BIT_OCIE]) ||
            (icf_reg && ctrl_reg[`PCT_BIT_ICIE]);
    end
end
endmodule // pct_timer

// [pct_timer_asserts.sv]
// Purpose: port checks for pct_timer
// Assumes: control, port data and misc registers reset to zero
// Notes: counter is unseen, so counter reads are checked relative to each other
`timescale 1ns/1ps
module pct_timer_asserts (
    input wire core_clk,
    input wire arst_n,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    input wire [7:0] regRdData,
    input wire capturePin,
    input wire pwmPin,
    input wire compareOutPin,
    input wire compareOutEn,
    input wire timerIrq
);
reg [4:0] ctl;
reg [2:0] sh;
reg [3:0] acc;
reg [7:0] lowQ;
reg tinEver;
default clocking cb @(posedge core_clk); endclocking
default disable iff (!arst_n);
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        ctl <= 5'h00;
        sh <= 3'h0;
        acc <= 4'h0;
        lowQ <= 8'h00;
        tinEver <= 1'b0;
    end else begin
        acc <= {regRdStb && regAddr == 8'h17, regRdStb && regAddr == 8'h16, regRdStb && regAddr == 8'h15,
            regWrStb && regAddr == 8'h17};
        if (regWrStb && regAddr == 8'h15)
            ctl <= regWrData[4:0];
        if (regWrStb && regAddr == 8'h17)
            lowQ <= regWrData;
        if (regWrStb && regAddr == 8'h12)
            sh[2] <= regWrData[7];
        if (regWrStb && regAddr == 8'h3c)
            sh[1] <= regWrData[0];
        if (regWrStb && regAddr == 8'h3b)
            sh[0] <= regWrData[6];
        if (regWrStb && regAddr == 8'h3b && regWrData[7])
            tinEver <= 1'b1;
    end
end
ctl_bits_a: assert property (acc[1] |-> regRdData[4:0] == ctl) else $error("control bits wrong");
irq_mask_a: assert property (ctl[4:2] == 3'b000 |=> !timerIrq) else $error("irq not masked");
cnt_step_a: assert property (acc[3] && $past(acc[3]) |-> regRdData == $past(regRdData) + 8'h01) else
    $error("counter step wrong");
hi_stale_a: assert property (acc[2] && $past(acc[2]) |-> regRdData == $past(regRdData)) else
    $error("high byte changed");
lo_load_a: assert property (acc[3] && $past(acc[0]) |-> regRdData == lowQ) else $error("counter load wrong");
cmp_en_a: assert property ($stable(sh) && $past(sh) == $past(sh, 2) |-> compareOutEn == sh[0]) else
    $error("compare enable wrong");
pin_data_a: assert property ($stable(sh) && $past(sh) == $past(sh, 2) && !sh[2] |-> pwmPin == sh[1]) else
    $error("pin data wrong");
cap_off_a: assert property (!tinEver && acc[1] |-> !regRdData[7]) else $error("capture while disabled");
endmodule // pct_timer_asserts
bind pct_timer pct_timer_asserts chk (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .capturePin(capturePin), .pwmPin(pwmPin), .compareOutPin(compareOutPin),
    .compareOutEn(compareOutEn), .timerIrq(timerIrq));

// [test_pct_timer.sv]
// Purpose: self-checking bench for pct_timer
// Assumes: 20 MHz clock
// Notes: driver queues read expectations, a monitor compares them
`timescale 1ns/1ps
module test_pct_timer;
reg core_clk = 1'b0;
reg arst_n = 1'b0;
reg [7:0] regAddr = 8'h00;
reg [7:0] regWrData = 8'h00;
reg regWrStb = 1'b0;
reg regRdStb = 1'b0;
reg capturePin = 1'b0;
reg rdPend = 1'b0;
wire [7:0] regRdData;
wire pwmPin, compareOutPin, compareOutEn, timerIrq;
integer errors = 0;
integer n_compared = 0;
integer i, k, hi;
reg [31:0] seed = 32'd77911;
reg [7:0] expQ[$];
reg [7:0] mskQ[$];
reg [7:0] e, m;
always #25 core_clk = ~core_clk;
pct_timer dut (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .capturePin(capturePin),
    .pwmPin(pwmPin), .compareOutPin(compareOutPin), .compareOutEn(compareOutEn), .timerIrq(timerIrq));
function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    end
endfunction
task chk(input [63:0] nm, input [15:0] seen, input [15:0] ex);
    begin
        n_compared = n_compared + 1;
        if (seen !== ex) begin
            errors = errors + 1;
            $display("BAD %0s expected %h seen %h", nm, ex, seen);
        end
    end
endtask
task wr(input [7:0] a, input [7:0] v);
    begin
        regWrStb <= 1'b1;
        regRdStb <= 1'b0;
        regAddr <= a;
        regWrData <= v;
        @(posedge core_clk);
    end
endtask
// Each task drives both strobes, so back-to-back accesses need no idle between them
task rd(input [7:0] a, input [7:0] ex, input [7:0] mk);
    begin
        expQ.push_back(ex);
        mskQ.push_back(mk);
        regWrStb <= 1'b0;
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
    end
endtask
task idle(input integer n);
    begin
        regWrStb <= 1'b0;
        regRdStb <= 1'b0;
        repeat (n) @(posedge core_clk);
    end
endtask
task finish_test;
    begin
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
endtask
always @(posedge core_clk) begin
    if (rdPend) begin
        e = expQ.pop_front();
        m = mskQ.pop_front();
        chk("rdata", {8'h00, regRdData & m}, {8'h00, e & m});
    end
    rdPend <= regRdStb;
end
initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rd(8'h15, 8'h00, 8'hff);
    rd(8'h40, 8'h00, 8'hff);
    for (i = 0; i < 4; i = i + 1) begin
        seed = xs(seed);
        wr(8'h15, seed[7:0]);
        rd(8'h15, seed[7:0] & 8'h1f, 8'hff);
        // High byte kept below ff so no wrap or match can raise a flag here
        wr(8'h16, seed[15:8] & 8'h7f);
        wr(8'h17, seed[23:16]);
        rd(8'h17, seed[23:16], 8'hff);
        rd(8'h16, seed[15:8] & 8'h7f, 8'hff);
        rd(8'h16, seed[15:8] & 8'h7f, 8'hff);
        rd(8'h17, seed[23:16] + 8'h03, 8'hff);
        rd(8'h17, seed[23:16] + 8'h04, 8'hff);
    end
    wr(8'h16, 8'hff);
    wr(8'h17, 8'hf0);
    wr(8'h15, 8'h04);
    idle(20);
    chk("irq", timerIrq, 1'b1);
    rd(8'h15, 8'h64, 8'hff);
    rd(8'h17, 8'h00, 8'h00);
    rd(8'h15, 8'h44, 8'hff);
    wr(8'h15, 8'h08);
    idle(3);
    chk("irq", timerIrq, 1'b1);
    rd(8'h15, 8'h48, 8'hff);
    wr(8'h19, 8'hff);
    rd(8'h15, 8'h08, 8'hff);
    wr(8'h3b, 8'hc0);
    // Rising edge first, then falling, so the pin needs only one move per pass
    for (k = 1; k >= 0; k = k - 1) begin
        wr(8'h15, {6'h04, k[0], 1'b0});
        idle(1);
        capturePin <= k[0];
        idle(8);
        chk("irq", timerIrq, 1'b1);
        rd(8'h15, {6'h24, k[0], 1'b0}, 8'h9f);
        rd(8'h1b, 8'h00, 8'h00);
        rd(8'h15, {6'h04, k[0], 1'b0}, 8'h9f);
    end
    // Level bit set, then run the counter through the reset compare value
    wr(8'h15, 8'h01);
    wr(8'h16, 8'hff);
    wr(8'h17, 8'hf0);
    idle(24);
    chk("cmp_pin", compareOutPin, 1'b1);
    chk("cmp_en", compareOutEn, 1'b1);
    wr(8'h3c, 8'h01);
    idle(4);
    // 16-bit period left out to keep the run short
    for (k = 1; k < 4; k = k + 1) begin
        seed = xs(seed);
        wr(8'h12, {6'h20, k[1:0]});
        if (k == 1)
            wr(8'h13, 8'he1);
        wr(8'h14, seed[7:0]);
        wr(8'h16, 8'hff);
        wr(8'h17, 8'hf0);
        idle(40);
        hi = 0;
        for (i = 0; i < (65536 >> k); i = i + 1) begin
            hi = hi + pwmPin;
            @(posedge core_clk);
        end
        chk("pwm_high", hi[15:0], {8'he1, seed[7:0]} & ((16'h0001 << (16 - k)) - 16'h0001));
    end
    idle(3);
    finish_test;
end
endmodule // test_pct_timer
